// ---- src/axwp_buf.sv ----
// Two-entry buffer with valid and ready on both sides and a registered ready.
`timescale 1ns/100ps
`default_nettype none
module axwp_buf #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import axwp_pkg::*;

  logic [WIDTH-1:0] slot_q [AXWP_BUF_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = slot_q[rd_ptr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // Ready comes from a flop, so it looks at the count after this cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= 2'h0;
      in_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != 2'(AXWP_BUF_DEPTH));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- src/axwp_mem.sv ----
// Byte-writable memory array with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module axwp_mem #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 10
) (
  input wire logic core_clk,
  input wire logic [DATA_W/8-1:0] wr_lane_en,
  input wire logic [ADDR_W-1:0] wr_index,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_index,
  output logic [DATA_W-1:0] rd_data
);
  import axwp_pkg::*;

  // Each byte lane keeps its own array, so no two processes write one variable.
  for (genvar g = 0; g < DATA_W/AXWP_LANE_BITS; g++) begin : g_lane
    logic [AXWP_LANE_BITS-1:0] lane_q [2**ADDR_W];

    always_ff @(posedge core_clk) begin
      if (wr_lane_en[g]) begin
        lane_q[wr_index] <= wr_data[g*AXWP_LANE_BITS +: AXWP_LANE_BITS];
      end
    end

    always_ff @(posedge core_clk) begin
      rd_data[g*AXWP_LANE_BITS +: AXWP_LANE_BITS] <= lane_q[rd_index];
    end
  end
endmodule
`default_nettype wire

// ---- src/axwp_pkg.sv ----
// Shared constants and types for the AXI4 write port of the block memory.
package axwp_pkg;
  localparam int AXWP_ADDR_W = 32;
  localparam int AXWP_LEN_W = 8;
  localparam int AXWP_SIZE_W = 3;
  localparam int AXWP_BURST_W = 2;
  localparam int AXWP_RESP_W = 2;
  localparam int AXWP_ID_MAX_W = 16;
  localparam int AXWP_ID_MIN_W = 1;
  localparam int AXWP_LANE_BITS = 8;
  localparam int AXWP_BUF_DEPTH = 2;
  localparam logic [AXWP_BURST_W-1:0] AXWP_BURST_FIXED = 2'h0;
  localparam logic [AXWP_BURST_W-1:0] AXWP_BURST_INCR = 2'h1;
  localparam logic [AXWP_BURST_W-1:0] AXWP_BURST_WRAP = 2'h2;
  localparam logic [AXWP_RESP_W-1:0] AXWP_RESP_OKAY = 2'h0;
  localparam logic [AXWP_ADDR_W-1:0] AXWP_ADDR_ONE = 32'h00000001;

  // Captured write address and control fields.
  typedef struct packed {
    logic [AXWP_ID_MAX_W-1:0] id;
    logic [AXWP_ADDR_W-1:0] addr;
    logic [AXWP_LEN_W-1:0] len;
    logic [AXWP_SIZE_W-1:0] size;
    logic [AXWP_BURST_W-1:0] burst;
  } axwp_aw_t;

  typedef enum logic [1:0] {
    AXWP_IDLE,
    AXWP_DATA,
    AXWP_RESP
  } axwp_state_t;
endpackage

// ---- src/axwp_write_port.sv ----
// AXI4 write-side slave front end of a block memory.
// Summary of operation
// [R1] Everything samples and changes on the rising edge of the one clock.
// [R2] The port is held idle while reset is asserted, released when it drops.
// [R3] Memory mode may take a write ID; peripheral mode ignores IDs.
// [R4] Response ID is 1 to 16 bits, only with IDs in memory mode.
// [R5] Response ID equals the ID captured with that write address.
// [R6] Address names the first beat; later beat addresses are derived here.
// [R7] Burst length field sets exactly how many beats the port accepts.
// [R8] Master keeps transfer size within the data bus width.
// [R9] Peripheral mode treats every beat as full bus width.
// [R10] Memory mode handles incrementing and wrapping bursts by type and size.
// [R11] Peripheral mode treats every burst as incrementing.
// [R12] Master holds address and controls stable until address ready.
// [R13] Address ready is high only when an address can be taken.
// [R14] Data width is 32 to 256 in memory mode, 8 to 256 otherwise.
// [R15] One strobe per byte lane; only strobed lanes are written.
// [R16] Master marks the final beat with write-last, never earlier beats.
// [R17] Master raises data valid only with meaningful data and strobes.
// [R18] Data ready is high only when a beat can be taken.
// [R19] The write response code is always a normal completion.
// [R20] Responses exist only in memory mode with IDs enabled.
// [R21] Wrapping bursts wrap at beat count times size, aligned to that.
`timescale 1ns/100ps
`default_nettype none
module axwp_write_port #(
  parameter bit MEM_MODE = 1'b1,
  parameter bit ID_EN = 1'b1,
  parameter int ID_W = 4,
  parameter int DATA_W = 32,
  parameter int MEM_AW = 10
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ID_W-1:0] s_axi_awid,
  input wire logic [axwp_pkg::AXWP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [axwp_pkg::AXWP_LEN_W-1:0] s_axi_awlen,
  input wire logic [axwp_pkg::AXWP_SIZE_W-1:0] s_axi_awsize,
  input wire logic [axwp_pkg::AXWP_BURST_W-1:0] s_axi_awburst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wlast,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [ID_W-1:0] s_axi_bid,
  output logic [axwp_pkg::AXWP_RESP_W-1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MEM_AW-1:0] rd_index,
  output logic [DATA_W-1:0] rd_data
);
  import axwp_pkg::*;

  // [R14] Lanes follow width
  localparam int BYTES = DATA_W / AXWP_LANE_BITS;
  localparam int LB = $clog2(BYTES);
  localparam int BEAT_W = DATA_W + BYTES + 1;
  localparam logic [AXWP_SIZE_W-1:0] FULL_SIZE = AXWP_SIZE_W'(LB);
  localparam bit ID_ON = MEM_MODE && ID_EN;
  localparam bit RESP_EN = MEM_MODE && ID_EN;

  //////////////////////////////////////////////////////////////////////////////

  axwp_state_t state_q;
  axwp_aw_t aw_in;
  axwp_aw_t aw_q;
  logic [AXWP_ADDR_W-1:0] addr_q;
  logic [AXWP_ADDR_W-1:0] addr_d;
  logic [AXWP_LEN_W-1:0] beat_q;
  logic aw_hs;
  logic beat_valid;
  logic beat_ready;
  logic beat_pop;
  logic beat_last;
  logic [BEAT_W-1:0] beat;
  logic [DATA_W-1:0] beat_data;
  logic [BYTES-1:0] beat_strb;
  logic [BYTES-1:0] lane_en;
  logic [AXWP_ADDR_W-1:0] step;
  logic [AXWP_ADDR_W-1:0] aligned;
  logic [AXWP_ADDR_W-1:0] wrap_mask;
  logic [AXWP_ADDR_W-1:0] next_incr;

  assign aw_hs = s_axi_awvalid && s_axi_awready;

  // [R3] IDs only in memory mode
  // [R9] Peripheral beats full width
  // [R11] Peripheral bursts incrementing
  always_comb begin
    aw_in.id = '0;
    if (ID_ON) begin
      aw_in.id = AXWP_ID_MAX_W'(s_axi_awid);
    end
    aw_in.addr = s_axi_awaddr;
    aw_in.len = s_axi_awlen;
    aw_in.size = MEM_MODE ? s_axi_awsize : FULL_SIZE;
    aw_in.burst = MEM_MODE ? s_axi_awburst : AXWP_BURST_INCR;
  end

  //////////////////////////////////////////////////////////////////////////////

  // [R1] Single edge state machine
  // [R2] Reset holds port idle
  // [R13] Address ready while idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= AXWP_IDLE;
      s_axi_awready <= 1'b0;
    end else begin
      case (state_q)
        AXWP_IDLE: begin
          s_axi_awready <= !aw_hs;
          if (aw_hs) begin
            state_q <= AXWP_DATA;
          end
        end
        AXWP_DATA: begin
          if (beat_pop && beat_last) begin
            state_q <= RESP_EN ? AXWP_RESP : AXWP_IDLE;
            s_axi_awready <= !RESP_EN;
          end
        end
        AXWP_RESP: begin
          if (s_axi_bvalid && s_axi_bready) begin
            state_q <= AXWP_IDLE;
            s_axi_awready <= 1'b1;
          end
        end
        default: begin
          state_q <= AXWP_IDLE;
          s_axi_awready <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_q <= '0;
    end else if (aw_hs) begin
      aw_q <= aw_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Data may arrive before its address; the buffer then fills and stalls it.
  axwp_buf #(
    .WIDTH(BEAT_W)
  ) u_buf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(s_axi_wvalid),
    .in_ready(s_axi_wready),
    .in_data({s_axi_wstrb, s_axi_wdata, s_axi_wlast}),
    .out_valid(beat_valid),
    .out_ready(beat_ready),
    .out_data(beat)
  );

  // [R18] Beats drain only in data phase
  assign beat_ready = (state_q == AXWP_DATA);
  assign beat_pop = beat_valid && beat_ready;
  assign beat_strb = beat[BEAT_W-1 -: BYTES];
  assign beat_data = beat[DATA_W:1];
  // [R7] Beat count from length field
  assign beat_last = (beat_q == aw_q.len);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      beat_q <= '0;
    end else if (aw_hs) begin
      beat_q <= '0;
    end else if (beat_pop) begin
      beat_q <= beat_q + AXWP_LEN_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // [R6] Later beat addresses
  // [R10] Type and size steer step
  // [R21] Wrap at total size
  assign step = AXWP_ADDR_ONE << aw_q.size;
  assign aligned = addr_q & ~(step - AXWP_ADDR_ONE);
  assign next_incr = aligned + step;
  assign wrap_mask = ((AXWP_ADDR_W'(aw_q.len) + AXWP_ADDR_ONE) << aw_q.size) - AXWP_ADDR_ONE;

  always_comb begin
    case (aw_q.burst)
      AXWP_BURST_WRAP: addr_d = (addr_q & ~wrap_mask) | (next_incr & wrap_mask);
      AXWP_BURST_FIXED: addr_d = addr_q;
      default: addr_d = next_incr;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_q <= '0;
    end else if (aw_hs) begin
      addr_q <= aw_in.addr;
    end else if (beat_pop) begin
      addr_q <= addr_d;
    end
  end

  // [R15] Strobed lanes only
  assign lane_en = beat_pop ? beat_strb : '0;

  axwp_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(MEM_AW)
  ) u_mem (
    .core_clk(core_clk),
    .wr_lane_en(lane_en),
    .wr_index(addr_q[LB +: MEM_AW]),
    .wr_data(beat_data),
    .rd_index(rd_index),
    .rd_data(rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////

  // [R4] Response ID width
  // [R5] Return captured ID
  // [R19] Always normal completion
  // [R20] Response only with IDs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bid <= '0;
      s_axi_bresp <= AXWP_RESP_OKAY;
    end else begin
      s_axi_bresp <= AXWP_RESP_OKAY;
      if (RESP_EN && state_q == AXWP_DATA && beat_pop && beat_last) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bid <= ID_W'(aw_q.id);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  logic [ID_W-1:0] last_id_h;
  logic [8:0] beats_h;
  always_ff @(posedge core_clk) begin
    if (aw_hs) begin
      last_id_h <= ID_ON ? s_axi_awid : '0;
      beats_h <= '0;
    end else if (beat_pop) begin
      beats_h <= beats_h + 9'h001;
    end
  end

  sequence seq_aw_hs;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence seq_resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  chk_aw_ready_drop: assert property ( // [R13]
    @(posedge core_clk) disable iff (sys_rst)
    seq_aw_hs |=> !s_axi_awready && state_q == AXWP_DATA)
    else $error("address ready stayed high after address taken");

  chk_aw_ready_busy: assert property ( // [R13]
    @(posedge core_clk) disable iff (sys_rst)
    state_q != AXWP_IDLE |-> !s_axi_awready)
    else $error("address ready high while a burst is open");

  chk_resp_id_match: assert property ( // [R5]
    @(posedge core_clk) disable iff (sys_rst)
    s_axi_bvalid |-> s_axi_bid == last_id_h)
    else $error("response ID differs from captured address ID");

  chk_resp_okay_code: assert property ( // [R19]
    @(posedge core_clk) disable iff (sys_rst)
    s_axi_bvalid |-> s_axi_bresp == AXWP_RESP_OKAY)
    else $error("write response not normal completion");

  chk_no_resp_periph: assert property ( // [R20]
    @(posedge core_clk) disable iff (sys_rst)
    !RESP_EN |-> !s_axi_bvalid)
    else $error("response raised without IDs in memory mode");

  chk_resp_hold: assert property ( // [R5]
    @(posedge core_clk) disable iff (sys_rst)
    seq_resp_wait |=> s_axi_bvalid && $stable(s_axi_bid))
    else $error("response dropped or changed before ready");

  chk_beat_total: assert property ( // [R7]
    @(posedge core_clk) disable iff (sys_rst)
    state_q == AXWP_DATA && beat_pop && beat_last
    |=> beats_h == 9'(aw_q.len) + 9'h001)
    else $error("burst closed after wrong number of beats");

  chk_strobe_lanes: assert property ( // [R15]
    @(posedge core_clk) disable iff (sys_rst)
    (lane_en & ~beat_strb) == '0 && (!beat_pop -> lane_en == '0))
    else $error("byte lane written without its strobe");

  chk_drain_phase: assert property ( // [R18]
    @(posedge core_clk) disable iff (sys_rst)
    lane_en != '0 |-> state_q == AXWP_DATA)
    else $error("beat consumed outside data phase");

  chk_wrap_window: assert property ( // [R21]
    @(posedge core_clk) disable iff (sys_rst)
    state_q == AXWP_DATA && aw_q.burst == AXWP_BURST_WRAP && beat_pop
    |=> (addr_q & ~wrap_mask) == (aw_q.addr & ~wrap_mask))
    else $error("wrapping address left its window");

  chk_incr_aligned: assert property ( // [R10]
    @(posedge core_clk) disable iff (sys_rst)
    state_q == AXWP_DATA && aw_q.burst == AXWP_BURST_INCR && beat_pop && !beat_last
    |=> (addr_q & (step - AXWP_ADDR_ONE)) == '0 && addr_q > $past(addr_q))
    else $error("incrementing address not aligned or not rising");

  chk_periph_full: assert property ( // [R11]
    @(posedge core_clk) disable iff (sys_rst)
    !MEM_MODE && state_q == AXWP_DATA
    |-> aw_q.burst == AXWP_BURST_INCR && aw_q.size == FULL_SIZE)
    else $error("peripheral burst not full width incrementing");

  chk_reset_idle: assert property ( // [R2]
    @(posedge core_clk)
    sys_rst |=> !s_axi_bvalid && !s_axi_awready && state_q == AXWP_IDLE)
    else $error("port not idle after reset");

  chk_resp_after_burst: assert property ( // [R20]
    @(posedge core_clk) disable iff (sys_rst)
    RESP_EN && state_q == AXWP_DATA && beat_pop && beat_last |=> s_axi_bvalid)
    else $error("response missing after final beat");
endmodule
`default_nettype wire

// ---- testbench/axwp_master_model.sv ----
// Bus master model that drives the write side of the block memory port.
`timescale 1ns/100ps
`default_nettype none
module axwp_master_model #(
  parameter int ID_W = 4
) (
  input wire logic core_clk,
  output logic [ID_W-1:0] s_axi_awid,
  output logic [axwp_pkg::AXWP_ADDR_W-1:0] s_axi_awaddr,
  output logic [axwp_pkg::AXWP_LEN_W-1:0] s_axi_awlen,
  output logic [axwp_pkg::AXWP_SIZE_W-1:0] s_axi_awsize,
  output logic [axwp_pkg::AXWP_BURST_W-1:0] s_axi_awburst,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wlast,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [ID_W-1:0] s_axi_bid,
  input wire logic [axwp_pkg::AXWP_RESP_W-1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready
);
  import axwp_pkg::*;
  logic [ID_W-1:0] got_bid;
  logic [1:0] got_bresp;
  logic saw_full;
  logic aw_leak;
  initial begin
    {s_axi_awid, s_axi_awaddr, s_axi_awlen, s_axi_awsize, s_axi_awburst} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_wlast, s_axi_bready} = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] beat_addr(input logic [31:0] a, input logic [7:0] len,
      input logic [2:0] sz, input logic [1:0] kind, input int k);
    logic [31:0] tot;
    logic [31:0] base;
    tot = ({24'h0, len} + 32'h1) << sz;
    base = a & ~(tot - 32'h1);
    if (kind == AXWP_BURST_WRAP) beat_addr = base + ((a + (32'(k) << sz) - base) % tot);
    else if (kind == AXWP_BURST_INCR && k > 0) beat_addr = ((a >> sz) << sz) + (32'(k) << sz);
    else beat_addr = a;
  endfunction
  function automatic logic [3:0] lane_mask(input logic [31:0] a, input logic [2:0] sz);
    for (int i = 0; i < 4; i++) begin
      lane_mask[i] = (i >= a[1:0]) && (i <= (a[1:0] | ((1 << sz) - 1)));
    end
  endfunction
  function automatic logic [31:0] beat_data(input logic [3:0] id, input int k,
      input logic [31:0] a);
    beat_data = {8'(k), 4'h5, id, a[15:0]};
  endfunction
  ////////////////////////////////////////////////////////////
  // Hold until ready
  task automatic send_aw(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
      input logic [2:0] sz, input logic [1:0] kind);
    @(negedge core_clk);
    s_axi_awid = id;
    s_axi_awaddr = a;
    s_axi_awlen = len;
    s_axi_awsize = sz;
    s_axi_awburst = kind;
    s_axi_awvalid = 1'b1;
    while (s_axi_awready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = ~a;
  endtask
  task automatic send_w(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
      input logic [2:0] sz, input logic [1:0] kind, input logic [3:0] strb, input int gap);
    logic [31:0] ba;
    @(negedge core_clk);
    for (int k = 0; k <= int'(len); k++) begin
      ba = beat_addr(a, len, sz, kind, k);
      s_axi_wdata = beat_data(id, k, ba);
      s_axi_wstrb = strb & lane_mask(ba, sz);
      s_axi_wlast = (k == int'(len));
      s_axi_wvalid = 1'b1;
      while (s_axi_wready !== 1'b1) begin
        saw_full = 1'b1;
        @(negedge core_clk);
      end
      @(negedge core_clk);
      if (gap > 0 && k < int'(len)) begin
        s_axi_wvalid = 1'b0;
        s_axi_wdata = ~s_axi_wdata;
        repeat (gap) @(negedge core_clk);
      end
    end
    s_axi_wvalid = 1'b0;
    s_axi_wlast = 1'b0;
    s_axi_wdata = ~s_axi_wdata;
  endtask
  task automatic burst(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
      input logic [2:0] sz, input logic [1:0] kind, input logic [3:0] strb, input int gap,
      input int awd, input int bw);
    int n;
    saw_full = 1'b0;
    aw_leak = 1'b0;
    got_bid = 'x;
    got_bresp = 'x;
    fork
      send_w(id, a, len, sz, kind, strb, gap);
      begin
        repeat (awd) @(negedge core_clk);
        send_aw(id, a, len, sz, kind);
      end
    join
    n = 0;
    while (s_axi_bvalid !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    repeat (bw) begin
      if (s_axi_awready !== 1'b0) aw_leak = 1'b1;
      @(negedge core_clk);
    end
    s_axi_bready = 1'b1;
    got_bid = (s_axi_bvalid === 1'b1) ? s_axi_bid : 'x;
    got_bresp = s_axi_bresp;
    @(negedge core_clk);
    s_axi_bready = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_axi_write_port_mem_slave.sv ----
// Self-checking bench for the memory write port.
`timescale 1ns/100ps
`default_nettype none
module test_axi_write_port_mem_slave;
  import axwp_pkg::*;
  logic core_clk, sys_rst, awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic [3:0] awid, bid, wstrb;
  logic [31:0] awaddr, wdata, rd_data, exp_mem[0:1023];
  logic [7:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst, bresp;
  logic [9:0] rd_index;
  logic [31:0] p_rd_data;
  logic p_awready, p_bvalid;
  bit p_cmp = 1'b0;
  bit exp_ok[0:1023];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  axwp_write_port #(.MEM_MODE(1'b1), .ID_EN(1'b1), .ID_W(4))
      axwp_write_port_inst (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awid(awid),
      .s_axi_awaddr(awaddr), .s_axi_awlen(awlen), .s_axi_awsize(awsize),
      .s_axi_awburst(awburst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wlast(wlast), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bid(bid), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .rd_index(rd_index), .rd_data(rd_data));
  // Peripheral-mode copy follows the same master and never answers on the response side.
  if (1) begin : g_periph
    axwp_write_port #(.MEM_MODE(1'b0)) axwp_write_port_inst (.core_clk(core_clk),
        .sys_rst(sys_rst), .s_axi_awid(awid), .s_axi_awaddr(awaddr), .s_axi_awlen(awlen),
        .s_axi_awsize(awsize), .s_axi_awburst(awburst), .s_axi_awvalid(awvalid),
        .s_axi_awready(p_awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wlast(wlast), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bid(),
        .s_axi_bresp(), .s_axi_bvalid(p_bvalid), .s_axi_bready(bready),
        .rd_index(rd_index), .rd_data(p_rd_data));
  end
  axwp_master_model axwp_master_model_inst (.core_clk(core_clk),
      .s_axi_awid(awid), .s_axi_awaddr(awaddr), .s_axi_awlen(awlen), .s_axi_awsize(awsize),
      .s_axi_awburst(awburst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wlast(wlast), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bid(bid), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready));
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // No scenario should come near this; a hang ends the run as a failure.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_mem;
    for (int i = 0; i < 1024; i++) begin
      if (exp_ok[i]) begin
        rd_index = i[9:0];
        @(negedge core_clk);
        check(rd_data, exp_mem[i]);
        if (p_cmp) check(p_rd_data, exp_mem[i]);
      end
    end
  endtask
  task automatic run(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
      input logic [2:0] sz, input logic [1:0] kind, input logic [3:0] strb, input int gap,
      input int awd, input int bw);
    logic [31:0] ba;
    logic [31:0] d;
    logic [3:0] m;
    axwp_master_model_inst.burst(id, a, len, sz, kind, strb, gap, awd, bw);
    for (int k = 0; k <= int'(len); k++) begin
      ba = axwp_master_model_inst.beat_addr(a, len, sz, kind, k);
      m = strb & axwp_master_model_inst.lane_mask(ba, sz);
      d = axwp_master_model_inst.beat_data(id, k, ba);
      for (int b = 0; b < 4; b++) begin
        if (m[b]) exp_mem[ba[11:2]][b*8 +: 8] = d[b*8 +: 8];
      end
      exp_ok[ba[11:2]] = 1'b1;
    end
    check(axwp_master_model_inst.got_bid, id);
    check(axwp_master_model_inst.got_bresp, AXWP_RESP_OKAY);
    check(p_bvalid, 1'b0);
    check(p_awready, 1'b1);
    check_mem();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (2) @(negedge core_clk);
    check(awready, 1'b0);
    check(wready, 1'b0);
    check(bvalid, 1'b0);
    sys_rst = 1'b0;
    @(negedge core_clk);
    check(awready, 1'b1);
  endtask
  // Full-width incrementing bursts only, so the peripheral copy must match as well.
  task automatic t_long;
    p_cmp = 1'b1;
    run(4'h3, 32'h400, 8'h00, 3'h2, AXWP_BURST_INCR, 4'hF, 0, 0, 0);
    run(4'h1, 32'h0, 8'hFF, 3'h2, AXWP_BURST_INCR, 4'hF, 0, 0, 0);
    p_cmp = 1'b0;
  endtask
  task automatic t_narrow;
    run(4'h2, 32'h202, 8'h03, 3'h1, AXWP_BURST_INCR, 4'hF, 0, 0, 0);
  endtask
  task automatic t_wrap;
    run(4'h6, 32'h108, 8'h03, 3'h2, AXWP_BURST_WRAP, 4'hF, 0, 0, 0);
    run(4'h7, 32'h11A, 8'h03, 3'h1, AXWP_BURST_WRAP, 4'hF, 0, 0, 0);
    run(4'hB, 32'h600, 8'h02, 3'h2, AXWP_BURST_FIXED, 4'hF, 0, 0, 0);
  endtask
  task automatic t_strobe;
    run(4'h8, 32'h40, 8'h01, 3'h2, AXWP_BURST_INCR, 4'h5, 0, 0, 0);
    run(4'hA, 32'h80, 8'h00, 3'h2, AXWP_BURST_INCR, 4'hA, 0, 0, 0);
  endtask
  task automatic t_fill;
    run(4'h9, 32'h300, 8'h03, 3'h2, AXWP_BURST_INCR, 4'hF, 0, 6, 0);
    check(axwp_master_model_inst.saw_full, 1'b1);
  endtask
  task automatic t_stall;
    run(4'hF, 32'h500, 8'h02, 3'h2, AXWP_BURST_INCR, 4'hF, 2, 0, 3);
    check(axwp_master_model_inst.aw_leak, 1'b0);
  endtask
  initial begin
    sys_rst = 1'b1;
    rd_index = 10'h0;
    t_reset();
    t_long();
    t_narrow();
    t_wrap();
    t_strobe();
    t_fill();
    t_stall();
    close_out();
  end
endmodule
`default_nettype wire
